/* pkg/i2c_client_pkg.sv */
// Purpose: Shared constants and types of the I2C client block.
// Assumes: 32-bit AXI4-Lite register bus, 8-bit byte addresses.
// Notes:   Offsets are byte addresses of aligned words.
package i2c_client_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD  = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_FLAG = 8'h0c;
   localparam logic [7:0] OFF_MASK = 8'h10;
   localparam logic [7:0] OFF_DATA = 8'h14;
   // ****************************************
   // Field positions and values
   // ****************************************
   localparam int CT_EN    = 7;
   localparam int CT_RATE  = 8;
   localparam int CT_STRETCH_AFTER_ACK_MODE = 10;
   localparam int CT_ACKA  = 11;
   localparam int FL_AHIT  = 0;
   localparam int FL_BRDY  = 1;
   localparam int FL_STOP  = 2;
   localparam logic [11:0] CTRL_RST  = 12'h000;
   localparam logic [2:0]  FLAG_RST  = 3'h0;
   localparam logic [1:0]  CMD_ACK   = 2'h3;
   localparam logic [1:0]  RATE_HS   = 2'h2;
   localparam logic [4:0]  HOST_CODE = 5'h01;
   localparam logic [3:0]  BYTE_BITS = 4'h8;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
   // ****************************************
   // Client sequencer states
   // ****************************************
   typedef enum logic [10:0] {
      S_IDLE  = 11'h001,
      S_ADDR  = 11'h002,
      S_AHOLD = 11'h004,
      S_ACK   = 11'h008,
      S_XHOLD = 11'h010,
      S_RX    = 11'h020,
      S_RHOLD = 11'h040,
      S_TXW   = 11'h080,
      S_TX    = 11'h100,
      S_TACK  = 11'h200,
      S_WAIT  = 11'h400
   } state_t;
endpackage

/* verilog/i2c_line_watch.sv */
// Purpose: Synchronise SCL and SDA and find edges, Start and Stop.
// Assumes: Pins are asynchronous to clk; SCL far slower than clk.
// Notes:   Event outputs are one-cycle pulses, two cycles after the pin.
`timescale 1ns/1ps
module i2c_line_watch
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // Pins
   input  wire logic scl_i,
   input  wire logic sda_i,
   // Synchronised view
   output logic      scl_s,
   output logic      sda_s,
   output logic      scl_rise,
   output logic      scl_fall,
   output logic      start_det,
   output logic      stop_det
);
   logic [1:0] scl_m_q;
   logic [1:0] sda_m_q;
   logic       scl_p_q;
   logic       sda_p_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         scl_m_q <= 2'h3;
         sda_m_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_m_q <= {scl_m_q[0], scl_i};
         sda_m_q <= {sda_m_q[0], sda_i};
         scl_p_q <= scl_m_q[1];
         sda_p_q <= sda_m_q[1];
      end
   end

   assign scl_s     = scl_m_q[1];
   assign sda_s     = sda_m_q[1];
   assign scl_rise  = scl_m_q[1] & ~scl_p_q;
   assign scl_fall  = ~scl_m_q[1] & scl_p_q;
   // SDA moving while SCL stays high marks a bus condition.
   assign start_det = scl_m_q[1] & scl_p_q & sda_p_q & ~sda_m_q[1];
   assign stop_det  = scl_m_q[1] & scl_p_q & ~sda_p_q & sda_m_q[1];
endmodule

/* verilog/i2c_client.sv */
// Purpose: I2C client with address match, stretching, byte hand-over.
// Assumes: AXI4-Lite register access; SCL sampled by clk.
// Notes:   7-bit addressing only; one byte of data buffered each way.
// Behaviour
// - After Start, compare address; on mismatch ignore until next Start.
// - Address match sets the address-hit flag.
// - Without stretch-after-ack mode, hold SCL low after a match until command 0x3 or an address-hit clear.
// - Direction bit changes only on an accepted address.
// - Collision releases both lines silently and sets the clash status bit.
// - Host read: ACK then byte-ready requests data; NACK waits for Start.
// - Host write: ACK then accept data, restart or Stop; NACK waits.
// - Command 0x3 sends the acknowledge, acting by current direction.
// - Writing one to address-hit clears it and sends the selected acknowledge.
// - Stretch-after-ack mode acks automatically, then flags and stretches.
// - Byte-ready set per byte moved; received bytes acked per action bit.
// - Host read: shifting starts when software writes the data register.
// - After a received byte, set byte-ready and hold SCL low until serviced.
// - Host NACK on a sent byte sets nack-got and releases SDA.
// - Stop sets the stop-seen flag if the client was addressed, and returns to idle.
// - Rate 0x2 with stretch mode enters high speed after host code until Stop.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module i2c_client
   import i2c_client_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // I2C pins
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // Interrupt
   output logic             irq
);
   // ****************************************
   // Declarations
   // ****************************************
   state_t      state_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic        aw_have_q, w_have_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [11:0] ctrl_q;
   logic [2:0]  flags_q, mask_q, fl_set, fl_clr;
   logic        irq_q, scl_oe_q, sda_oe_q, pin_lo_q;
   logic        dir_q, clash_q, nackg_q, hs_q, addressed_q;
   logic        nack_q, ack_addr_q;
   logic        ev_ahit_q, ev_brdy_q, ev_stop_q, ev_clash_q, ev_nack_q;
   logic [7:0]  sh_q, rx_q;
   logic [3:0]  cnt_q;
   logic        sda_s, scl_rise, scl_fall, start_det, stop_det;
   logic        wr_go, cmd_ack, w1c_ahit, w1c_brdy, data_wr, wr_ok;
   logic [31:0] rd_word;
   logic        rd_ok;
   logic [11:0] ctrl_m;
   logic        en, stretch_after_ack_mode, acknowledge_action_bit;

   assign en     = ctrl_q[CT_EN];
   assign stretch_after_ack_mode  = ctrl_q[CT_STRETCH_AFTER_ACK_MODE];
   assign acknowledge_action_bit = ctrl_q[CT_ACKA];

   i2c_line_watch u_watch
   (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .scl_s     (),
      .sda_s     (sda_s),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .start_det (start_det),
      .stop_det  (stop_det)
   );
   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   assign wr_go    = aw_have_q & w_have_q & ~bvalid_q;
   assign cmd_ack  = wr_go & (awaddr_q[7:2] == OFF_CMD[7:2]) & wstrb_q[0] & (wdata_q[1:0] == CMD_ACK);
   assign w1c_ahit = wr_go & (awaddr_q[7:2] == OFF_FLAG[7:2]) & wstrb_q[0] & wdata_q[FL_AHIT];
   assign w1c_brdy = wr_go & (awaddr_q[7:2] == OFF_FLAG[7:2]) & wstrb_q[0] & wdata_q[FL_BRDY];
   assign data_wr  = wr_go & (awaddr_q[7:2] == OFF_DATA[7:2]) & wstrb_q[0];
   assign ctrl_m   = {{4{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_ok    = (awaddr_q[7:2] <= OFF_DATA[7:2]) & (awaddr_q[1:0] == 2'h0);

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OK;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end
      else
      begin
         if (awvalid && awready_q)
         begin
            awaddr_q  <= awaddr;
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q)
         begin
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OK : RESP_ERR;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
         end
         if (bvalid_q && bready)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (araddr)
         OFF_CTRL: rd_word = {20'h00000, ctrl_q};
         OFF_CMD:  rd_word = 32'h0000_0000;
         OFF_STAT: rd_word = {28'h0000000, hs_q, nackg_q, clash_q, dir_q};
         OFF_FLAG: rd_word = {29'h0, flags_q};
         OFF_MASK: rd_word = {29'h0, mask_q};
         OFF_DATA: rd_word = {24'h000000, rx_q};
         default:  rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= RESP_OK;
      end
      else if (arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_ok ? RESP_OK : RESP_ERR;
      end
      else if (rvalid_q && rready)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ****************************************
   // Registers, status and interrupt
   // ****************************************
   assign fl_set = {ev_stop_q, ev_brdy_q, ev_ahit_q};
   assign fl_clr = (wr_go && awaddr_q[7:2] == OFF_FLAG[7:2] && wstrb_q[0]) ? wdata_q[2:0] : 3'h0;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrl_q  <= CTRL_RST;
         mask_q  <= FLAG_RST;
         flags_q <= FLAG_RST;
         clash_q <= 1'b0;
         nackg_q <= 1'b0;
         irq_q   <= 1'b0;
      end
      else
      begin
         if (wr_go && awaddr_q[7:2] == OFF_CTRL[7:2])
         begin
            ctrl_q <= (ctrl_q & ~ctrl_m) | (wdata_q[11:0] & ctrl_m);
         end
         if (wr_go && awaddr_q[7:2] == OFF_MASK[7:2] && wstrb_q[0])
         begin
            mask_q <= wdata_q[2:0];
         end
         // A hardware set in the clearing cycle wins.
         flags_q <= (flags_q & ~fl_clr) | fl_set;
         // The clash stays visible until software takes the next hit.
         clash_q <= (clash_q & ~w1c_ahit) | ev_clash_q;
         nackg_q <= (nackg_q & ~data_wr) | ev_nack_q;
         irq_q   <= |(flags_q & mask_q);
      end
   end

   // ****************************************
   // Bus sequencer
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q     <= S_IDLE;
         scl_oe_q    <= 1'b0;
         sda_oe_q    <= 1'b0;
         pin_lo_q    <= 1'b0;
         sh_q        <= 8'h00;
         rx_q        <= 8'h00;
         cnt_q       <= 4'h0;
         dir_q       <= 1'b0;
         hs_q        <= 1'b0;
         nack_q      <= 1'b0;
         ack_addr_q  <= 1'b0;
         addressed_q <= 1'b0;
         ev_ahit_q   <= 1'b0;
         ev_brdy_q   <= 1'b0;
         ev_stop_q   <= 1'b0;
         ev_clash_q  <= 1'b0;
         ev_nack_q   <= 1'b0;
      end
      else
      begin
         pin_lo_q   <= 1'b0;
         ev_ahit_q  <= 1'b0;
         ev_brdy_q  <= 1'b0;
         ev_stop_q  <= 1'b0;
         ev_clash_q <= 1'b0;
         ev_nack_q  <= 1'b0;
         if (!en)
         begin
            state_q     <= S_IDLE;
            scl_oe_q    <= 1'b0;
            sda_oe_q    <= 1'b0;
            hs_q        <= 1'b0;
            addressed_q <= 1'b0;
         end
         else if (start_det)
         begin
            state_q  <= S_ADDR;
            cnt_q    <= 4'h0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
         end
         else if (stop_det)
         begin
            state_q     <= S_IDLE;
            ev_stop_q   <= addressed_q;
            addressed_q <= 1'b0;
            hs_q        <= 1'b0;
            scl_oe_q    <= 1'b0;
            sda_oe_q    <= 1'b0;
         end
         else
         begin
            case (state_q)
               S_IDLE, S_WAIT:
               begin
                  state_q <= state_q;
               end
               S_ADDR, S_RX:
               begin
                  if (scl_rise)
                  begin
                     sh_q  <= {sh_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end
                  if (scl_fall && cnt_q == BYTE_BITS && state_q == S_RX)
                  begin
                     rx_q      <= sh_q;
                     ev_brdy_q <= 1'b1;
                     scl_oe_q  <= 1'b1;
                     state_q   <= S_RHOLD;
                  end
                  else if (scl_fall && cnt_q == BYTE_BITS)
                  begin
                     if (sh_q[7:1] == ctrl_q[6:0])
                     begin
                        dir_q       <= sh_q[0];
                        addressed_q <= 1'b1;
                        ev_ahit_q   <= 1'b1;
                        ack_addr_q  <= 1'b1;
                        if (stretch_after_ack_mode)
                        begin
                           nack_q   <= acknowledge_action_bit;
                           sda_oe_q <= ~acknowledge_action_bit;
                           state_q  <= S_ACK;
                        end
                        else
                        begin
                           scl_oe_q <= 1'b1;
                           state_q  <= S_AHOLD;
                        end
                     end
                     else
                     begin
                        // Nobody acks a host code; the released SDA is that NACK.
                        hs_q    <= hs_q | (sh_q[7:3] == HOST_CODE && ctrl_q[CT_RATE+:2] == RATE_HS && stretch_after_ack_mode);
                        state_q <= S_IDLE;
                     end
                  end
               end
               S_AHOLD, S_RHOLD:
               begin
                  if (cmd_ack || (state_q == S_AHOLD ? w1c_ahit : w1c_brdy))
                  begin
                     nack_q   <= acknowledge_action_bit;
                     sda_oe_q <= ~acknowledge_action_bit;
                     scl_oe_q <= 1'b0;
                     state_q  <= S_ACK;
                  end
               end
               S_ACK:
               begin
                  if (scl_fall)
                  begin
                     sda_oe_q   <= 1'b0;
                     cnt_q      <= 4'h0;
                     ack_addr_q <= 1'b0;
                     if (nack_q)
                     begin
                        state_q <= S_IDLE;
                     end
                     else if (ack_addr_q && stretch_after_ack_mode && flags_q[FL_AHIT])
                     begin
                        scl_oe_q <= 1'b1;
                        state_q  <= S_XHOLD;
                     end
                     else if (ack_addr_q && dir_q)
                     begin
                        ev_brdy_q <= 1'b1;
                        scl_oe_q  <= 1'b1;
                        state_q   <= S_TXW;
                     end
                     else
                     begin
                        state_q <= S_RX;
                     end
                  end
               end
               S_XHOLD:
               begin
                  if (!flags_q[FL_AHIT])
                  begin
                     ev_brdy_q <= dir_q;
                     scl_oe_q  <= dir_q;
                     state_q   <= dir_q ? S_TXW : S_RX;
                  end
               end
               S_TXW:
               begin
                  if (data_wr)
                  begin
                     sh_q     <= wdata_q[7:0];
                     sda_oe_q <= ~wdata_q[7];
                     scl_oe_q <= 1'b0;
                     cnt_q    <= 4'h1;
                     state_q  <= S_TX;
                  end
               end
               S_TX:
               begin
                  if (scl_rise && !sda_oe_q && !sda_s)
                  begin
                     ev_clash_q <= 1'b1;
                     sda_oe_q   <= 1'b0;
                     scl_oe_q   <= 1'b0;
                     state_q    <= S_IDLE;
                  end
                  else if (scl_fall && cnt_q == BYTE_BITS)
                  begin
                     sda_oe_q <= 1'b0;
                     state_q  <= S_TACK;
                  end
                  else if (scl_fall)
                  begin
                     sda_oe_q <= ~sh_q[6];
                     sh_q     <= {sh_q[6:0], 1'b0};
                     cnt_q    <= cnt_q + 4'h1;
                  end
               end
               S_TACK:
               begin
                  if (scl_rise)
                  begin
                     nack_q    <= sda_s;
                     ev_nack_q <= sda_s;
                  end
                  if (scl_fall)
                  begin
                     ev_brdy_q <= 1'b1;
                     scl_oe_q  <= ~nack_q;
                     state_q   <= nack_q ? S_WAIT : S_TXW;
                  end
               end
               default:
               begin
                  state_q  <= S_IDLE;
                  scl_oe_q <= 1'b0;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign scl_oe  = scl_oe_q;
   assign sda_oe  = sda_oe_q;
   assign scl_o   = pin_lo_q;
   assign sda_o   = pin_lo_q;
   assign irq     = irq_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence clash_seen;
      en && !start_det && !stop_det && state_q == S_TX && scl_rise && !sda_oe_q && !sda_s;
   endsequence

   a_hold_stretch:   assert property (state_q == S_AHOLD || state_q == S_RHOLD |-> scl_oe_q)
      else $error("SCL not held while waiting for software.");
   a_dir_update:     assert property ($changed(dir_q) |-> $past(state_q) == S_ADDR)
      else $error("Direction changed outside an address.");
   a_hit_flag:       assert property (ev_ahit_q |=> flags_q[FL_AHIT])
      else $error("Address hit did not set its flag.");
   a_cmd_ack:        assert property (en && !start_det && !stop_det && state_q == S_AHOLD && cmd_ack
                                      |=> state_q == S_ACK && sda_oe_q == !acknowledge_action_bit)
      else $error("Acknowledge command not carried out.");
   a_hit_clear:      assert property (state_q == S_AHOLD && w1c_ahit && !ev_ahit_q |=> !flags_q[FL_AHIT])
      else $error("Address hit flag not cleared.");
   a_rx_hold:        assert property (en && !start_det && !stop_det && state_q == S_RX && scl_fall && cnt_q == BYTE_BITS
                                      |=> state_q == S_RHOLD && scl_oe_q ##1 flags_q[FL_BRDY])
      else $error("Received byte not flagged and held.");
   a_nack_release:   assert property (state_q == S_WAIT |-> !sda_oe_q && !scl_oe_q)
      else $error("Lines driven after host NACK.");
   a_stop_idle:      assert property (en && stop_det && !start_det |=> state_q == S_IDLE && !hs_q)
      else $error("Stop did not return to idle.");
   a_clash_release:  assert property (clash_seen |=> !sda_oe_q && !scl_oe_q ##1 clash_q)
      else $error("Collision did not release the bus.");
   a_tx_start:       assert property (en && !start_det && !stop_det && state_q == S_TXW && data_wr
                                      |=> state_q == S_TX && sda_oe_q == !$past(wdata_q[7]))
      else $error("Data write did not start shifting.");
   a_hs_keep:        assert property (hs_q && en && !stop_det |=> hs_q)
      else $error("High speed left without a Stop.");
endmodule

/* tb/i2c_host_model.sv */
// Purpose: Behavioural I2C bus host for the client bench.
// Assumes: Open-drain lines with pull-ups; SCL period 125 ns.
// Notes:   Waits on SCL whenever the client stretches it.
`timescale 1ns/1ps
module i2c_host_model
(
   // Bus levels
   input  wire logic scl,
   input  wire logic sda,
   // Host pull-downs
   output logic      scl_dn,
   output logic      sda_dn
);
   initial
   begin
      scl_dn = 1'b0;
      sda_dn = 1'b0;
   end
   // ****
   // Bit, byte and framing tasks
   // ****
   task automatic bit_io(input logic b, output logic r);
      sda_dn = !b;
      #31.25;
      scl_dn = 1'b0;
      wait (scl);
      #31.25;
      r = sda;
      #31.25;
      scl_dn = 1'b1;
      #31.25;
   endtask
   task automatic start();
      sda_dn = 1'b1;
      #62.5;
      scl_dn = 1'b1;
      #31.25;
   endtask
   // SDA is released only while SCL is high, so the client sees a Stop.
   task automatic stop();
      sda_dn = 1'b1;
      #31.25;
      scl_dn = 1'b0;
      wait (scl);
      #62.5;
      sda_dn = 1'b0;
      #62.5;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(a, n);
   endtask
endmodule

/* tb/tb_i2c_client_addr_data_ctrl.sv */
// Purpose: Self-checking bench of the I2C client.
// Assumes: AXI4-Lite master tasks; behavioural bus host.
// Notes:   Own address has its top bit set to stay clear of host codes.
`timescale 1ns/1ps
module tb_i2c_client_addr_data_ctrl
   import i2c_client_pkg::*;
;
   logic        clk, sys_rst, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
   logic        irq, scl_oe, sda_oe, scl_dn, sda_dn, nak, scl_o, sda_o;
   logic [1:0]  bresp, rresp;
   logic [6:0]  own;
   logic [7:0]  awaddr, araddr, d, q;
   logic [31:0] wdata, rdata, r;
   int          n_mismatch, n_checks;
   wire         scl = !((scl_oe & !scl_o) | scl_dn);
   wire         sda = !((sda_oe & !sda_o) | sda_dn);
   // Answers are always accepted at once, so bready and rready stay high.
   i2c_client DUT (.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
      .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1),
      .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .irq);
   i2c_host_model host (.scl(scl), .sda(sda), .scl_dn(scl_dn), .sda_dn(sda_dn));
   // ****
   // Tasks
   // ****
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      r = rdata;
      if (e !== 32'hffffffff)
         chk(r, e);
   endtask
   task automatic wirq();
      repeat (4000)
         if (!irq)
            @(posedge clk);
      chk(irq, 1'b1);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = !clk;
   end
   initial
   begin
      #200000;
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      {sys_rst, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = {1'b1, 51'h0};
      own = 7'h40 | 7'($urandom(32'h642e811d));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      wr(OFF_MASK, 32'h7);
      chk(bresp, RESP_OK);
      wr(OFF_CTRL, 32'h80 | own);
      rdchk(8'h3c, 32'h0);
      chk(rresp, RESP_ERR);
      wr(8'h3c, 32'h0);
      chk(bresp, RESP_ERR);
      chk({scl_o, sda_o}, 32'h0);
      host.start();
      host.xfer({own ^ 7'h01, 1'b0}, 1'b1, q, nak);
      chk(nak, 1'b1);
      chk(irq, 1'b0);
      host.stop();
      rdchk(OFF_FLAG, 32'h0);
      host.start();
      fork
         host.xfer({own, 1'b0}, 1'b1, q, nak);
         begin
            wirq();
            rdchk(OFF_FLAG, 32'h1);
            rdchk(OFF_STAT, 32'h0);
            chk(scl, 1'b0);
            wr(OFF_FLAG, 32'h1);
         end
      join
      chk(nak, 1'b0);
      d = 8'($urandom);
      fork
         host.xfer(d, 1'b1, q, nak);
         begin
            wirq();
            rdchk(OFF_FLAG, 32'h2);
            rdchk(OFF_DATA, d);
            wr(OFF_FLAG, 32'h2);
         end
      join
      chk(nak, 1'b0);
      host.stop();
      rdchk(OFF_FLAG, 32'h4);
      wr(OFF_FLAG, 32'h4);
      host.start();
      fork
         host.xfer({own, 1'b1}, 1'b1, q, nak);
         begin
            wirq();
            rdchk(OFF_STAT, 32'h1);
            wr(OFF_CMD, CMD_ACK);
         end
      join
      chk(nak, 1'b0);
      repeat (20) @(posedge clk);
      rdchk(OFF_FLAG, 32'hffffffff);
      chk(r[1], 1'b1);
      for (int i = 0; i < 2; i++)
      begin
         d = 8'($urandom);
         fork
            host.xfer(8'hff, i[0], q, nak);
            wr(OFF_DATA, d);
         join
         chk(q, d);
      end
      rdchk(OFF_STAT, 32'h5);
      host.stop();
      rdchk(OFF_FLAG, 32'h7);
      wr(OFF_FLAG, 32'h7);
      wr(OFF_MASK, 32'h6);
      wr(OFF_CTRL, 32'h480 | own);
      host.start();
      host.xfer({own, 1'b0}, 1'b1, q, nak);
      chk(nak, 1'b0);
      fork
         host.stop();
         begin
            repeat (40) @(posedge clk);
            chk(scl, 1'b0);
            rdchk(OFF_FLAG, 32'h1);
            chk(irq, 1'b0);
            wr(OFF_FLAG, 32'h1);
         end
      join
      wr(OFF_CTRL, 32'h680 | own);
      host.start();
      host.xfer({HOST_CODE, 3'($urandom)}, 1'b1, q, nak);
      chk(nak, 1'b1);
      rdchk(OFF_STAT, 32'hffffffff);
      chk(r[3], 1'b1);
      host.stop();
      rdchk(OFF_STAT, 32'hffffffff);
      chk(r[3], 1'b0);
      wr(OFF_CTRL, 32'hc80 | own);
      host.start();
      host.xfer({own, 1'b0}, 1'b1, q, nak);
      chk(nak, 1'b1);
      host.stop();
      wr(OFF_CTRL, 32'h480 | own);
      // The host holds SDA low under a sent one, so the client must back off.
      d = 8'h80 | 8'($urandom);
      host.start();
      host.xfer({own, 1'b1}, 1'b1, q, nak);
      fork
         host.xfer(8'h00, 1'b1, q, nak);
         begin
            wr(OFF_FLAG, 32'h1);
            wr(OFF_DATA, d);
         end
      join
      chk(nak, 1'b1);
      host.stop();
      rdchk(OFF_STAT, 32'h3);
      host.start();
      host.xfer({own, 1'b0}, 1'b1, q, nak);
      rdchk(OFF_STAT, 32'h2);
      fork
         host.stop();
         wr(OFF_FLAG, 32'h1);
      join
      rdchk(OFF_STAT, 32'h0);
      complete_run();
   end
endmodule
